// [design/aba_alu.sv]
// add / add-with-carry / and / single-bit-and datapath with a small register port
// assumes the decoder supplies fetched operand bytes and the current flags with the request
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps

// Summary of operation
// - add-with-carry: dst plus src plus carry
// - add: dst plus src, no carry in
// - additions set carry from bit seven out
// - additions set zero on zero result
// - additions set sign on negative result
// - additions flag overflow on same-sign operands, sign flip
// - additions clear decimal-adjust flag
// - additions set half-carry from low nibble
// - and stores bitwise and of operands
// - and: keep c d h, z, s bit7, v cleared
// - bit-and into bit zero or chosen bit
// - bit-and opcode 67, 3 bytes, 6 cycles
// - bit-and: z on zero, s cleared, keep others
module aba_alu (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   // instruction request from the decoder
   input  wire logic        exec_req_i,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  mode_i,
   input  wire logic [7:0]  dst_i,
   input  wire logic [7:0]  src_i,
   input  wire logic [5:0]  flags_i,
   // result to the register file
   output logic             done_o,
   output logic             wr_dst_o,
   output logic             illegal_o,
   output logic      [7:0]  result_o,
   output logic      [5:0]  flags_o,
   output logic      [3:0]  wr_addr_o,
   output logic      [1:0]  len_o,
   output logic      [3:0]  cycles_o,
   // register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rd_data_o
);

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction : is_zero

   function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                          input logic b);
      logic [7:0] r;
      r      = v;
      r[idx] = b;
      put_bit = r;
   endfunction : put_bit

   // decode
   aba_pkg::aba_op_e dec_op;
   logic [1:0]       dec_len;
   logic [3:0]       dec_cyc;
   logic             dec_legal;

   aba_opdec u_dec (
      .opcode_i (opcode_i),
      .op_o     (dec_op),
      .len_o    (dec_len),
      .cyc_o    (dec_cyc),
      .legal_o  (dec_legal)
   );

   // state
   logic             ctrl_en_ff;
   logic             ill_seen_ff;
   logic [7:0]       op_cnt_ff;
   logic [7:0]       rd_data_ff;
   logic             done_ff;
   logic             wr_dst_ff;
   logic             illegal_ff;
   logic [7:0]       result_ff;
   logic [5:0]       flags_ff;
   logic [3:0]       wr_addr_ff;
   logic [1:0]       len_ff;
   logic [3:0]       cyc_ff;
   aba_pkg::aba_op_e op_ff;

   // request acceptance and adder
   wire logic       accept   = exec_req_i & ctrl_en_ff;
   wire logic       is_adc   = (dec_op == aba_pkg::ABA_OP_ADC);
   wire logic       is_add   = is_adc | (dec_op == aba_pkg::ABA_OP_ADD);
   wire logic       cin_use  = is_adc & flags_i[aba_pkg::FLG_C];
   wire logic [7:0] add_sum;
   wire logic       add_cout;
   wire logic       add_half;
   wire logic       add_ovf;

   aba_add8 #(
      .DATA_W (aba_pkg::DW)
   ) u_add (
      .a_i    (dst_i),
      .b_i    (src_i),
      .cin_i  (cin_use),
      .sum_o  (add_sum),
      .cout_o (add_cout),
      .half_o (add_half),
      .ovf_o  (add_ovf)
   );

   // single-bit form fields
   wire logic       band_sel  = mode_i[aba_pkg::BSEL_POS];
   wire logic [2:0] band_idx  = mode_i[aba_pkg::BIDX_MSB:aba_pkg::BIDX_LSB];
   wire logic [3:0] band_radr = mode_i[aba_pkg::RADR_MSB:aba_pkg::RADR_LSB];
   wire logic       band_b0   = dst_i[0] & src_i[band_idx];
   wire logic       band_bb   = dst_i[band_idx] & src_i[0];
   wire logic       band_bit  = band_sel ? band_bb : band_b0;
   wire logic [7:0] band_res  = band_sel ? put_bit(dst_i, band_idx, band_bb)
                                         : put_bit(dst_i, 3'h0, band_b0);
   wire logic [7:0] and_res   = dst_i & src_i;

   // result and flag selection
   logic [7:0] nxt_result;
   logic [5:0] nxt_flags;

   always_comb begin
      nxt_result = dst_i;
      nxt_flags  = flags_i;
      case (dec_op)
         aba_pkg::ABA_OP_ADC, aba_pkg::ABA_OP_ADD: begin
            nxt_result                 = add_sum;
            nxt_flags[aba_pkg::FLG_C]  = add_cout;
            nxt_flags[aba_pkg::FLG_Z]  = is_zero(add_sum);
            nxt_flags[aba_pkg::FLG_S]  = add_sum[7];
            nxt_flags[aba_pkg::FLG_V]  = add_ovf;
            nxt_flags[aba_pkg::FLG_D]  = 1'b0;
            nxt_flags[aba_pkg::FLG_H]  = add_half;
         end
         aba_pkg::ABA_OP_AND: begin
            nxt_result                 = and_res;
            nxt_flags[aba_pkg::FLG_Z]  = is_zero(and_res);
            nxt_flags[aba_pkg::FLG_S]  = and_res[7];
            nxt_flags[aba_pkg::FLG_V]  = 1'b0;
         end
         aba_pkg::ABA_OP_BAND: begin
            // overflow is left as it was: its value is undefined for this form
            nxt_result                 = band_res;
            nxt_flags[aba_pkg::FLG_Z]  = ~band_bit;
            nxt_flags[aba_pkg::FLG_S]  = 1'b0;
         end
         default: begin
            nxt_result = dst_i;
            nxt_flags  = flags_i;
         end
      endcase
   end

   // write-back register address: the working register of the single-bit form
   wire logic [3:0] nxt_wr_addr = (dec_op == aba_pkg::ABA_OP_BAND) ? band_radr : 4'h0;

   // execution pipeline stage
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         done_ff    <= 1'b0;
         wr_dst_ff  <= 1'b0;
         illegal_ff <= 1'b0;
         result_ff  <= aba_pkg::BYTE_RST;
         flags_ff   <= aba_pkg::FLAGS_RST;
         wr_addr_ff <= 4'h0;
         len_ff     <= 2'h0;
         cyc_ff     <= 4'h0;
         op_ff      <= aba_pkg::ABA_OP_NONE;
      end else begin
         done_ff    <= accept;
         wr_dst_ff  <= accept & dec_legal;
         illegal_ff <= accept & ~dec_legal;
         if (accept) begin
            result_ff  <= nxt_result;
            flags_ff   <= nxt_flags;
            wr_addr_ff <= nxt_wr_addr;
            len_ff     <= dec_len;
            cyc_ff     <= dec_cyc;
            op_ff      <= dec_op;
         end
      end
   end

   // register port decode
   wire logic wr_ctrl = wr_i & (addr_i == aba_pkg::REG_CTRL);
   wire logic wr_stat = wr_i & (addr_i == aba_pkg::REG_STATUS);
   wire logic ill_clr = wr_stat & wr_data_i[aba_pkg::STAT_ILL];
   wire logic ill_set = accept & ~dec_legal;
   wire logic [7:0] stat_word = {ill_seen_ff, 1'b0, flags_ff};
   wire logic [7:0] rd_word   =
      (addr_i == aba_pkg::REG_CTRL)   ? {7'h00, ctrl_en_ff} :
      (addr_i == aba_pkg::REG_STATUS) ? stat_word :
      (addr_i == aba_pkg::REG_RESULT) ? result_ff :
      (addr_i == aba_pkg::REG_COUNT)  ? op_cnt_ff : 8'h00;

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ctrl_en_ff  <= aba_pkg::CTRL_RST[aba_pkg::CTRL_EN];
         ill_seen_ff <= 1'b0;
         op_cnt_ff   <= aba_pkg::BYTE_RST;
         rd_data_ff  <= aba_pkg::BYTE_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_en_ff <= wr_data_i[aba_pkg::CTRL_EN];
         end
         // a new illegal opcode wins over a clear in the same cycle
         if (ill_set) begin
            ill_seen_ff <= 1'b1;
         end else if (ill_clr) begin
            ill_seen_ff <= 1'b0;
         end
         if (accept & dec_legal) begin
            op_cnt_ff <= op_cnt_ff + 8'h01;
         end
         rd_data_ff <= rd_i ? rd_word : 8'h00;
      end
   end

   assign done_o    = done_ff;
   assign wr_dst_o  = wr_dst_ff;
   assign illegal_o = illegal_ff;
   assign result_o  = result_ff;
   assign flags_o   = flags_ff;
   assign wr_addr_o = wr_addr_ff;
   assign len_o     = len_ff;
   assign cycles_o  = cyc_ff;
   assign rd_data_o = rd_data_ff;

   // independent reference terms for the checks
   wire logic       chk_cin  = (opcode_i[7:4] == 4'h1) & flags_i[aba_pkg::FLG_C];
   wire logic [8:0] chk_sum9 = {1'b0, dst_i} + {1'b0, src_i} + {8'h00, chk_cin};
   wire logic [4:0] chk_nib  = {1'b0, dst_i[3:0]} + {1'b0, src_i[3:0]} + {4'h0, chk_cin};
   wire logic       chk_add  = accept & is_add;
   wire logic       chk_and  = accept & (dec_op == aba_pkg::ABA_OP_AND);
   wire logic       chk_band = accept & (dec_op == aba_pkg::ABA_OP_BAND);

   a_adc_sum: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      accept && (opcode_i == aba_pkg::OPC_ADC_RR) |=>
         result_o == 8'($past(dst_i) + $past(src_i) + {7'h00, $past(flags_i[5])}))
      else $error("add-with-carry sum wrong");

   a_add_sum: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      accept && (opcode_i == aba_pkg::OPC_ADD_GL) |=>
         result_o == 8'($past(dst_i) + $past(src_i)))
      else $error("add sum wrong");

   a_carry_out: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_add |=> flags_o[aba_pkg::FLG_C] == $past(chk_sum9[8]))
      else $error("addition carry flag wrong");

   a_zero_add: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      done_o && (op_ff == aba_pkg::ABA_OP_ADC || op_ff == aba_pkg::ABA_OP_ADD) |->
         flags_o[aba_pkg::FLG_Z] == (result_o == 8'h00))
      else $error("addition zero flag wrong");

   a_sign_add: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_add |=> flags_o[aba_pkg::FLG_S] == $past(chk_sum9[7]))
      else $error("addition sign flag wrong");

   a_ovf_add: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_add |=> flags_o[aba_pkg::FLG_V] ==
         $past((dst_i[7] == src_i[7]) && (chk_sum9[7] != dst_i[7])))
      else $error("addition overflow flag wrong");

   a_dadj_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_add |=> !flags_o[aba_pkg::FLG_D] && done_o)
      else $error("decimal-adjust flag not cleared");

   a_half_carry: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_add |=> flags_o[aba_pkg::FLG_H] == $past(chk_nib[4]))
      else $error("half-carry flag wrong");

   a_adc_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      accept && (opcode_i == aba_pkg::OPC_ADC_RI) |=>
         len_o == 2'h2 && cycles_o == 4'h6 && wr_dst_o)
      else $error("add-with-carry decode wrong");

   a_add_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      accept && (opcode_i == aba_pkg::OPC_ADD_RR) |=> len_o == 2'h2 && cycles_o == 4'h4)
      else $error("add decode wrong");

   a_and_result: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_and |=> result_o == ($past(dst_i) & $past(src_i)))
      else $error("and result wrong");

   a_and_flags: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_and |=> !flags_o[aba_pkg::FLG_V] && flags_o[aba_pkg::FLG_S] == result_o[7] &&
         {flags_o[5], flags_o[1:0]} == $past({flags_i[5], flags_i[1:0]}))
      else $error("and flags wrong");

   a_and_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      accept && (opcode_i == aba_pkg::OPC_AND_GI) |=> len_o == 2'h3 && cycles_o == 4'h6)
      else $error("and decode wrong");

   a_band_keep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_band && !band_sel |=> result_o[7:1] == $past(dst_i[7:1]) &&
         result_o[0] == $past(dst_i[0] & src_i[band_idx]))
      else $error("bit-and into bit zero wrong");

   a_band_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_band |=> len_o == 2'h3 && cycles_o == 4'h6 && wr_addr_o == $past(mode_i[7:4]))
      else $error("bit-and decode wrong");

   a_band_flags: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_band |=> !flags_o[aba_pkg::FLG_S] &&
         {flags_o[5], flags_o[1:0]} == $past({flags_i[5], flags_i[1:0]}))
      else $error("bit-and flags wrong");

   a_refused_req: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      exec_req_i && !ctrl_en_ff |=> !done_o ##1 1'b1)
      else $error("request taken while disabled");

   c_adc_carry: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_add && is_adc && flags_i[aba_pkg::FLG_C] ##1 done_o);
   c_and_zero: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_and ##1 flags_o[aba_pkg::FLG_Z]);
   c_band_bitb: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      chk_band && band_sel ##1 wr_dst_o);
   c_illegal_op: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      accept && !dec_legal ##1 illegal_o);

endmodule : aba_alu

// [design/aba_pkg.sv]
// constants, opcodes and types of the add / and / bit-and datapath
// assumes the decoder hands over one instruction at a time with operands already fetched
package aba_pkg;

   localparam int unsigned DW = 8;
   localparam int unsigned FW = 6;

   // opcodes: add with carry
   localparam logic [7:0] OPC_ADC_RR  = 8'h12;
   localparam logic [7:0] OPC_ADC_RI  = 8'h13;
   localparam logic [7:0] OPC_ADC_GG  = 8'h14;
   localparam logic [7:0] OPC_ADC_GI  = 8'h15;
   localparam logic [7:0] OPC_ADC_GL  = 8'h16;
   // opcodes: plain add
   localparam logic [7:0] OPC_ADD_RR  = 8'h02;
   localparam logic [7:0] OPC_ADD_RI  = 8'h03;
   localparam logic [7:0] OPC_ADD_GG  = 8'h04;
   localparam logic [7:0] OPC_ADD_GI  = 8'h05;
   localparam logic [7:0] OPC_ADD_GL  = 8'h06;
   // opcodes: logical and
   localparam logic [7:0] OPC_AND_RR  = 8'h52;
   localparam logic [7:0] OPC_AND_RI  = 8'h53;
   localparam logic [7:0] OPC_AND_GG  = 8'h54;
   localparam logic [7:0] OPC_AND_GI  = 8'h55;
   localparam logic [7:0] OPC_AND_GL  = 8'h56;
   // opcode: single-bit and
   localparam logic [7:0] OPC_BAND    = 8'h67;

   // instruction length in bytes and execution time in cycles
   localparam logic [1:0] LEN_SHORT   = 2'h2;
   localparam logic [1:0] LEN_LONG    = 2'h3;
   localparam logic [3:0] CYC_FAST    = 4'h4;
   localparam logic [3:0] CYC_SLOW    = 4'h6;

   // flag vector positions
   localparam int unsigned FLG_C      = 5;
   localparam int unsigned FLG_Z      = 4;
   localparam int unsigned FLG_S      = 3;
   localparam int unsigned FLG_V      = 2;
   localparam int unsigned FLG_D      = 1;
   localparam int unsigned FLG_H      = 0;

   // second byte of the single-bit form
   localparam int unsigned BSEL_POS   = 0;
   localparam int unsigned BIDX_LSB   = 1;
   localparam int unsigned BIDX_MSB   = 3;
   localparam int unsigned RADR_LSB   = 4;
   localparam int unsigned RADR_MSB   = 7;

   // register map (byte addresses)
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_RESULT  = 4'h8;
   localparam logic [3:0] REG_COUNT   = 4'hc;
   localparam int unsigned CTRL_EN    = 0;
   localparam int unsigned STAT_ILL   = 7;
   localparam logic [7:0] CTRL_RST    = 8'h01;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [5:0] FLAGS_RST   = 6'h00;

   typedef enum logic [4:0] {
      ABA_OP_NONE = 5'h01,
      ABA_OP_ADC  = 5'h02,
      ABA_OP_ADD  = 5'h04,
      ABA_OP_AND  = 5'h08,
      ABA_OP_BAND = 5'h10
   } aba_op_e;

endpackage : aba_pkg

// [design/aba_add8.sv]
// byte adder with carry, half-carry and overflow outputs
// assumes pure combinational use inside the datapath
`timescale 1ns/10ps
module aba_add8 #(
   parameter int unsigned DATA_W = aba_pkg::DW
) (
   // operands
   input  wire logic [DATA_W-1:0] a_i,
   input  wire logic [DATA_W-1:0] b_i,
   input  wire logic              cin_i,
   // results
   output logic      [DATA_W-1:0] sum_o,
   output logic                   cout_o,
   output logic                   half_o,
   output logic                   ovf_o
);
   logic [DATA_W:0] full_sum;
   logic [4:0]      nib_sum;

   if (DATA_W < 5) begin : g_bad_width
      $error("aba_add8 needs at least five data bits");
   end

   assign full_sum = {1'b0, a_i} + {1'b0, b_i} + {{DATA_W{1'b0}}, cin_i};
   assign nib_sum  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
   assign sum_o    = full_sum[DATA_W-1:0];
   assign cout_o   = full_sum[DATA_W];
   assign half_o   = nib_sum[4];
   // same operand signs, result sign differs
   assign ovf_o    = (a_i[DATA_W-1] == b_i[DATA_W-1]) &&
                     (full_sum[DATA_W-1] != a_i[DATA_W-1]);
endmodule : aba_add8

// [design/aba_opdec.sv]
// opcode decoder: operation class, length and cycle count
// assumes the opcode is stable while the request is high
`timescale 1ns/10ps
module aba_opdec (
   // opcode in
   input  wire logic [7:0]    opcode_i,
   // decode out
   output aba_pkg::aba_op_e   op_o,
   output logic      [1:0]    len_o,
   output logic      [3:0]    cyc_o,
   output logic               legal_o
);
   always_comb begin
      op_o    = aba_pkg::ABA_OP_NONE;
      len_o   = aba_pkg::LEN_SHORT;
      cyc_o   = aba_pkg::CYC_FAST;
      legal_o = 1'b1;
      case (opcode_i)
         aba_pkg::OPC_ADC_RR: begin op_o = aba_pkg::ABA_OP_ADC; end
         aba_pkg::OPC_ADC_RI: begin
            op_o  = aba_pkg::ABA_OP_ADC;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         aba_pkg::OPC_ADC_GG, aba_pkg::OPC_ADC_GI, aba_pkg::OPC_ADC_GL: begin
            op_o  = aba_pkg::ABA_OP_ADC;
            len_o = aba_pkg::LEN_LONG;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         aba_pkg::OPC_ADD_RR: begin op_o = aba_pkg::ABA_OP_ADD; end
         aba_pkg::OPC_ADD_RI: begin
            op_o  = aba_pkg::ABA_OP_ADD;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         aba_pkg::OPC_ADD_GG, aba_pkg::OPC_ADD_GI, aba_pkg::OPC_ADD_GL: begin
            op_o  = aba_pkg::ABA_OP_ADD;
            len_o = aba_pkg::LEN_LONG;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         aba_pkg::OPC_AND_RR: begin op_o = aba_pkg::ABA_OP_AND; end
         aba_pkg::OPC_AND_RI: begin
            op_o  = aba_pkg::ABA_OP_AND;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         aba_pkg::OPC_AND_GG, aba_pkg::OPC_AND_GI, aba_pkg::OPC_AND_GL: begin
            op_o  = aba_pkg::ABA_OP_AND;
            len_o = aba_pkg::LEN_LONG;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         aba_pkg::OPC_BAND: begin
            op_o  = aba_pkg::ABA_OP_BAND;
            len_o = aba_pkg::LEN_LONG;
            cyc_o = aba_pkg::CYC_SLOW;
         end
         default: begin
            legal_o = 1'b0;
         end
      endcase
   end
endmodule : aba_opdec

// [tb/aba_dec_model.sv]
// behavioural decoder that feeds the datapath and register file that takes its write-back
// assumes the bench calls send and idle from its main sequence
`timescale 1ns/10ps
module aba_dec_model (
   // clock
   input  wire logic       clk_sys_i,
   // request to the datapath
   output logic            exec_req_o,
   output logic [7:0]      opcode_o,
   output logic [7:0]      mode_o,
   output logic [7:0]      dst_o,
   output logic [7:0]      src_o,
   output logic [5:0]      flags_o,
   // write back from the datapath
   input  wire logic       wr_dst_i,
   input  wire logic [3:0] wr_addr_i,
   input  wire logic [7:0] result_i
);
   logic [7:0] rf_ff [16];

   initial begin
      exec_req_o = 1'b0;
      opcode_o = 8'h00;
      mode_o = 8'h00;
      dst_o = 8'h00;
      src_o = 8'h00;
      flags_o = 6'h00;
   end

   always @(posedge clk_sys_i) begin
      if (wr_dst_i === 1'b1) begin
         rf_ff[wr_addr_i] <= result_i;
      end
   end

   task automatic send(input logic [7:0] op, m, d, s, input logic [5:0] f);
      @(posedge clk_sys_i);
      exec_req_o <= 1'b1;
      opcode_o <= op;
      mode_o <= m;
      dst_o <= d;
      src_o <= s;
      flags_o <= f;
   endtask : send

   // released lines show the inverse of their last value
   task automatic idle();
      @(posedge clk_sys_i);
      exec_req_o <= 1'b0;
      opcode_o <= ~opcode_o;
      mode_o <= ~mode_o;
      dst_o <= ~dst_o;
      src_o <= ~src_o;
      flags_o <= ~flags_o;
   endtask : idle
endmodule : aba_dec_model

// [tb/testbench.sv]
// self-checking bench for the add / and / bit-and datapath
// assumes a 100 MHz clock and the decoder model in aba_dec_model.sv
`timescale 1ns/10ps
`define chk_eq(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   logic        clk_sys_i, rstn_i, exec_req, done_o, wr_dst_o, illegal_o, wr, rd;
   logic [7:0]  opcode, mode, dst, src, result_o, wr_data, rd_data_o, rv;
   logic [5:0]  flags_in, flags_o;
   logic [3:0]  wr_addr_o, cycles_o, addr;
   logic [1:0]  len_o;
   int          err_total, samples_checked, cyc, n_legal;
   logic [25:0] exp_q[$];
   logic [7:0]  ops [15] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h02, 8'h03, 8'h04,
                             8'h05, 8'h06, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56};
   logic [7:0]  bad [5] = '{8'h17, 8'h07, 8'h57, 8'h01, 8'hff};
   logic [21:0] opnd [7] = '{{8'h10, 8'h03, 6'h3f}, {8'hff, 8'h01, 6'h00},
      {8'h7f, 8'h01, 6'h3f}, {8'h80, 8'h80, 6'h00}, {8'h0f, 8'h01, 6'h00},
      {8'h00, 8'h00, 6'h3f}, {8'h88, 8'h88, 6'h2a}};

   aba_alu u_aba_alu (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .exec_req_i(exec_req),
      .opcode_i(opcode), .mode_i(mode), .dst_i(dst), .src_i(src), .flags_i(flags_in),
      .done_o(done_o), .wr_dst_o(wr_dst_o), .illegal_o(illegal_o), .result_o(result_o),
      .flags_o(flags_o), .wr_addr_o(wr_addr_o), .len_o(len_o), .cycles_o(cycles_o),
      .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data_o));

   aba_dec_model u_aba_dec_model (.clk_sys_i(clk_sys_i), .exec_req_o(exec_req),
      .opcode_o(opcode), .mode_o(mode), .dst_o(dst), .src_o(src), .flags_o(flags_in),
      .wr_dst_i(wr_dst_o), .wr_addr_i(wr_addr_o), .result_i(result_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // expected {illegal, write, len, cycles, wr_addr, flags, result}
   function automatic logic [25:0] calc(input logic [7:0] op, m, d, s, input logic [5:0] f);
      logic [8:0] sum;
      logic [4:0] lo;
      logic [7:0] r;
      logic [5:0] nf;
      logic       ill, cin, bv;
      ill = 1'b0;
      nf = f;
      r = d;
      if (op == 8'h67) begin
         bv = m[0] ? (d[m[3:1]] & s[0]) : (d[0] & s[m[3:1]]);
         if (m[0]) r[m[3:1]] = bv;
         else r[0] = bv;
         nf[4] = ~bv;
         nf[3] = 1'b0;
         return {2'b01, 2'h3, 4'h6, m[7:4], nf, r};
      end
      if (!(op[7:4] inside {4'h0, 4'h1, 4'h5}) || op[3:0] < 4'h2 || op[3:0] > 4'h6) begin
         ill = 1'b1;
      end else if (op[7:4] == 4'h5) begin
         r = d & s;
         nf[4] = (r == 8'h00);
         nf[3] = r[7];
         nf[2] = 1'b0;
      end else begin
         cin = op[4] & f[5];
         sum = {1'b0, d} + {1'b0, s} + {8'h00, cin};
         lo = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
         r = sum[7:0];
         nf = {sum[8], r == 8'h00, r[7], (d[7] == s[7]) && (r[7] != d[7]), 1'b0, lo[4]};
      end
      return {ill, ~ill, (ill || op[3:0] < 4'h4) ? 2'h2 : 2'h3,
              (ill || op[3:0] == 4'h2) ? 4'h4 : 4'h6, 4'h0, nf, r};
   endfunction : calc

   task automatic go(input logic [7:0] op, m, d, s, input logic [5:0] f, input logic en);
      logic [25:0] e;
      e = calc(op, m, d, s, f);
      if (en) exp_q.push_back(e);
      if (en && !e[25]) n_legal++;
      u_aba_dec_model.send(op, m, d, s, f);
   endtask : go

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wr_data <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      @(posedge clk_sys_i);
      d = rd_data_o;
   endtask : reg_rd

   // answers are popped in order; a done with nothing pending is a refusal breach
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         final_report();
      end
      if (done_o === 1'b1) begin
         if (exp_q.size() == 0) `chk_eq(done_o, 1'b0)
         else `chk_eq({illegal_o, wr_dst_o, len_o, cycles_o, wr_addr_o, flags_o, result_o},
            exp_q.pop_front())
      end
   end

   initial begin
      rstn_i = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wr_data = 8'h00;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      #1 `chk_eq({done_o, result_o, flags_o, len_o, cycles_o}, 21'h0)
      reg_rd(4'h0, rv);
      `chk_eq(rv, 8'h01)
      foreach (ops[i]) foreach (opnd[j])
         go(ops[i], 8'h00, opnd[j][21:14], opnd[j][13:6], opnd[j][5:0], 1'b1);
      for (int k = 0; k < 16; k++)
         go(8'h67, {k[3:0], k[2:0], k[3]}, 8'h07, k[0] ? 8'hfa : 8'h05,
            k[0] ? 6'h3f : 6'h00, 1'b1);
      go(8'h67, 8'h12, 8'h07, 8'h05, 6'h00, 1'b1);
      foreach (bad[i]) go(bad[i], 8'h00, 8'h5a, 8'h3c, 6'h2a, 1'b1);
      u_aba_dec_model.idle();
      repeat (3) @(posedge clk_sys_i);
      `chk_eq(u_aba_dec_model.rf_ff[1], 8'h06)
      `chk_eq(exp_q.size() == 0, 1'b1)
      reg_rd(4'h8, rv);
      `chk_eq(rv, 8'h5a)
      reg_rd(4'h4, rv);
      `chk_eq(rv, 8'haa)
      reg_wr(4'h4, 8'h80);
      reg_rd(4'h4, rv);
      `chk_eq(rv, 8'h2a)
      reg_rd(4'hc, rv);
      `chk_eq(rv, n_legal[7:0])
      reg_wr(4'h8, 8'hff);
      reg_rd(4'h8, rv);
      `chk_eq(rv, 8'h5a)
      reg_rd(4'h2, rv);
      `chk_eq(rv, 8'h00)
      // disabled unit must ignore a request, then work again once enabled
      reg_wr(4'h0, 8'h00);
      go(8'h02, 8'h00, 8'h01, 8'h01, 6'h00, 1'b0);
      u_aba_dec_model.idle();
      reg_wr(4'h0, 8'h01);
      go(8'h02, 8'h00, 8'h01, 8'h01, 6'h00, 1'b1);
      u_aba_dec_model.idle();
      repeat (3) @(posedge clk_sys_i);
      `chk_eq(exp_q.size() == 0, 1'b1)
      final_report();
   end
endmodule : testbench
